// *** boot_source_loader_tb.sv ***
`include "bsl_cfg.svh"
module boot_source_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bsl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic power_down_n = 1'b1;
  logic debug_serial_in = 1'b0;
  logic card_boot_select = 1'b1;
  logic card_present = 1'b0;
  logic [7:0] core_stop = 8'h00;
  logic slow_clk_sel = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic rom_ok = 1'b0;
  logic card_en = 1'b0;
  logic ee_miso, ee_mosi;
  logic [6:0] ee_bit, ee_pos;
  logic [7:0] ee_cmd;
  logic osc_pll_stop, mem_page0_select_n, mem_page1_select_n;
  logic mem_output_enable_n, card_ready, ee_cs_n, ee_sck, slow_tick;
  logic fw_we, boot_run, debugger_start, control_cpu_rom, boot_fail;
  logic img_ready, rd_on, wr_on;
  logic [21:0] mem_addr;
  logic [15:0] mem_data, fw_addr, fw_data, reg_rdata, v;
  logic [7:0] card_sector, dsp_core_idle, img_byte, rd_b, wr_b;
  logic [22:0] start_addr;
  bsl_src_t boot_src;
  logic [7:0] img_mem [0:7];
  logic [7:0] wr_log [0:7];
  logic [31:0] fw_log [0:3];
  logic [3:0] idx, img_n;
  int fw_n, n_ack, n_wr, failures, n_checks, k;
  bsl_if bif();
  // Byte streams and memory contents
  wire card_valid = card_en && idx < img_n;
  wire img_valid = !card_en && idx < img_n;
  wire [7:0] card_byte = img_byte;
  assign img_byte = img_mem[idx[2:0]];
  assign mem_data = (!rom_ok || mem_addr > 22'h1) ? 16'h0000 :
    {8'h00, mem_addr[0] ? `BSL_SIG1 : `BSL_SIG0};
  wire rd_now = !bif.cs_n && !bif.rd_n && !bif.host_register_select;
  wire wr_now = !bif.cs_n && !bif.wr_n && !bif.host_register_select;
  // Serial memory: four dummy bytes, then the image, shifted on falling clock
  assign ee_pos = ee_bit - 7'h20;
  assign ee_miso = card_en && ee_bit >= 7'h20 &&
    img_mem[ee_pos[5:3]][3'h7 - ee_pos[2:0]];
  always @(negedge ee_sck or posedge ee_cs_n)
    ee_bit <= ee_cs_n ? 7'h0 : ee_bit + 7'h1;
  always @(posedge ee_sck)
    if (ee_bit < 7'h8)
      ee_cmd <= {ee_cmd[6:0], ee_mosi};

  bsl_dev u_bsl_dev (
    .clk, .rst_n, .power_down_n, .osc_pll_stop, .debug_serial_in,
    .card_boot_select, .hp(bif), .mem_addr, .mem_data, .mem_page0_select_n,
    .mem_page1_select_n, .mem_output_enable_n, .card_present, .card_byte,
    .card_valid, .card_ready, .card_sector, .ee_cs_n, .ee_sck, .ee_mosi,
    .ee_miso, .core_stop, .slow_clk_sel, .slow_tick, .fw_we, .fw_addr,
    .fw_data, .boot_run, .boot_src, .start_addr, .debugger_start,
    .control_cpu_rom, .dsp_core_idle, .boot_fail
  );
  bsl_host u_bsl_host (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .img_byte, .img_valid, .img_ready, .hp(bif)
  );
  bsl_chk_sva u_bsl_chk_sva (
    .clk, .rst_n, .cs_n(bif.cs_n), .rd_n(bif.rd_n), .irq(bif.irq),
    .host_register_select(bif.host_register_select),
    .host_d_oe(bif.host_d_oe), .dev_d_oe(bif.dev_d_oe), .power_down_n,
    .osc_pll_stop, .mem_page0_select_n, .mem_page1_select_n,
    .mem_output_enable_n, .ee_cs_n, .ee_sck, .core_stop, .dsp_core_idle,
    .control_cpu_rom, .boot_run, .boot_src
  );

  initial
  begin
    forever #5 clk = ~clk;
  end

  // Stream pacing, loaded words and host port bytes seen on the wire
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      idx <= 4'h0;
      fw_n <= 0;
      n_ack <= 0;
      n_wr <= 0;
      rd_on <= 1'b0;
      wr_on <= 1'b0;
    end
    else
    begin
      if ((card_valid && card_ready) || (img_valid && img_ready))
        idx <= idx + 4'h1;
      if (fw_we && fw_n < 4)
        fw_log[fw_n] <= {fw_addr, fw_data};
      fw_n <= fw_n + int'(fw_we);
      rd_on <= rd_now;
      wr_on <= wr_now;
      if (rd_now)
        rd_b <= bif.d;
      if (wr_now)
        wr_b <= bif.d;
      if (rd_on && !rd_now && rd_b == `BSL_HOST_ACK)
        n_ack <= n_ack + 1;
      if (wr_on && !wr_now && n_wr < 8)
        wr_log[n_wr[2:0]] <= wr_b;
      n_wr <= n_wr + int'(wr_on && !wr_now);
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic load(input logic [47:0] b, input logic [3:0] n);
    for (int i = 0; i < 8; i++)
      img_mem[i] = (i < 6) ? b[47 - 8 * i -: 8] : 8'h00;
    img_n = n;
  endtask

  task automatic boot_reset(input logic dbg, csel, rom, cen);
    @(posedge clk);
    rst_n <= 1'b0;
    debug_serial_in <= dbg;
    card_boot_select <= csel;
    rom_ok <= rom;
    card_en <= cen;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic wait_end();
    int i;
    for (i = 0; i < 8000; i++)
    begin
      if (boot_run === 1'b1 || boot_fail === 1'b1 || debugger_start === 1'b1)
        break;
      @(posedge clk);
    end
    failures += int'(i == 8000);
    #1;
  endtask

  task automatic ticks(input int n, output int t);
    t = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      t += int'(slow_tick);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #500000;
    failures++;
    close_out();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(32'(dsp_core_idle), 32'hff);
    chk(32'(control_cpu_rom), 32'h1);
    // Debug strap beats a valid ROM
    boot_reset(1'b1, 1'b1, 1'b1, 1'b0);
    wait_end();
    chk(32'(debugger_start), 32'h1);
    chk(32'(boot_run), 32'h0);
    // ROM signature beats card select
    boot_reset(1'b0, 1'b0, 1'b1, 1'b0);
    wait_end();
    chk(32'(boot_src), 32'(SRC_ROM));
    chk(32'(start_addr), 32'(`BSL_ROM_JUMP));
    @(posedge clk);
    core_stop <= 8'h05;
    slow_clk_sel <= 1'b1;
    ticks(4, k);
    chk(32'(dsp_core_idle), 32'h05);
    ticks(512, k);
    chk(32'(k), 32'd2);
    @(posedge clk);
    slow_clk_sel <= 1'b0;
    power_down_n <= 1'b0;
    ticks(2, k);
    chk(32'(osc_pll_stop), 32'h1);
    ticks(8, k);
    chk(32'(k), 32'd8);
    @(posedge clk);
    power_down_n <= 1'b1;
    // Card boot waits for presence
    load(48'h0200a1b2c3d4, 4'd6);
    boot_reset(1'b0, 1'b0, 1'b0, 1'b1);
    repeat (300) @(posedge clk);
    #1;
    chk(32'(boot_run), 32'h0);
    chk(32'(fw_n), 32'd0);
    chk(32'(card_sector), 32'h01);
    @(posedge clk);
    card_present <= 1'b1;
    wait_end();
    chk(32'(boot_src), 32'(SRC_CARD));
    chk(32'(fw_n), 32'd2);
    chk(fw_log[0], 32'h0000b2a1);
    chk(fw_log[1], 32'h0001d4c3);
    // Serial memory boot when the card is not selected
    load({`BSL_SIG0, `BSL_SIG1, 32'h0100e1f2}, 4'd0);
    boot_reset(1'b0, 1'b1, 1'b0, 1'b1);
    wait_end();
    chk(32'(boot_src), 32'(SRC_EE));
    chk(32'(fw_n), 32'd1);
    chk(fw_log[0], 32'h0000f2e1);
    chk(32'(ee_cmd), 32'(`BSL_EE_READ));
    // Host download after ROM and serial memory both fail
    load({`BSL_SIG0, `BSL_SIG1, 32'h11220000}, 4'd4);
    boot_reset(1'b0, 1'b1, 1'b0, 1'b0);
    reg_wr(`BSL_REG_LEN, 16'h0002);
    reg_wr(`BSL_REG_CTRL, 16'h0001);
    wait_end();
    chk(32'(boot_src), 32'(SRC_HOST));
    chk(32'(fw_n), 32'd2);
    chk(fw_log[0], {16'h0000, `BSL_SIG1, `BSL_SIG0});
    chk(fw_log[1], 32'h00012211);
    v = 16'h0000;
    for (int i = 0; i < 100 && v[1] !== 1'b1; i++)
      reg_rd(`BSL_REG_STAT, v);
    chk(32'(v), 32'h2);
    chk(32'(n_ack), 32'd2);
    chk(32'(n_wr), 32'd6);
    chk(32'({wr_log[1], wr_log[0]}), 32'h2);
    for (int i = 0; i < 4; i++)
      chk(32'(wr_log[i + 2]), 32'(img_mem[i]));
    reg_rd(2'h3, v);
    chk(32'(v), 32'h0);
    // Host image without signature is refused
    load({`BSL_SIG0, 40'h0011220000}, 4'd4);
    boot_reset(1'b0, 1'b1, 1'b0, 1'b0);
    reg_wr(`BSL_REG_LEN, 16'h0002);
    reg_wr(`BSL_REG_CTRL, 16'h0001);
    wait_end();
    chk(32'(boot_fail), 32'h1);
    chk(32'(boot_run), 32'h0);
    close_out();
  end
endmodule

// *** bsl_cfg.svh ***
`ifndef BSL_CFG_SVH
`define BSL_CFG_SVH
// Overview of operation
// - System holds reset low until clocks settle.
// - Reset release puts every DSP core idle.
// - Reset release starts control CPU from ROM.
// - Sense debug input first; high starts debugger.
// - ROM words 0,1 signature jumps to 400h.
// - Card select low: await card, load sector 1.
// - EEPROM signature bytes found: load and start.
// - Else host download: write ack byte, raise interrupt.
// - Host may poll status instead of interrupt.
// - Host sends word length, low byte first.
// - Host image begins with boot signature.
// - Image complete: ack byte again, then run.
// - Power-down low stops oscillator and PLL.
// - Exit power-down: raise input, then reset.
// - Firmware stops DSP cores individually.
// - Firmware selects divide-by-256 slow clock.
// - Logic clock is PLL at four times crystal.
// - Two 4M-word pages, each own select.
// - Output enable fixed cycles after chip select.
// - Host data read sets empty, clears interrupt.
// - EEPROM reached as SPI master, mode 0.
`define BSL_CLK_NS 10
`define BSL_SETTLE_NS 10000000
`define BSL_SETTLE_CYC (`BSL_SETTLE_NS / `BSL_CLK_NS)
`define BSL_PLL_MULT 4
`define BSL_SPI_HALF `BSL_PLL_MULT
`define BSL_SLOW_LAST 8'hff
// Boot signature, arbitrary value
`define BSL_SIG0 8'h5a
`define BSL_SIG1 8'h3c
`define BSL_ROM_JUMP 23'h000400
`define BSL_PAGE_BIT 22
`define BSL_HOST_ACK 8'hac
`define BSL_CARD_SECTOR 8'h01
`define BSL_EE_READ 8'h03
`define BSL_EE_SIG0_IDX 3'h4
`define BSL_EE_SIG1_IDX 3'h5
`define BSL_ST_TE 7
`define BSL_ST_RF 6
`define BSL_MEM_OE_DLY 2
`define BSL_MEM_OE_LEN 3
`define BSL_HOST_PRD_NS 50
`define BSL_HOST_STB_CYC \
  ((`BSL_HOST_PRD_NS + `BSL_CLK_NS - 1) / `BSL_CLK_NS)
`define BSL_REG_CTRL 2'h0
`define BSL_REG_LEN 2'h1
`define BSL_REG_STAT 2'h2
`endif

// *** bsl_chk_sva.sv ***
module bsl_chk_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host port
  input wire logic cs_n,
  input wire logic host_register_select,
  input wire logic rd_n,
  input wire logic irq,
  input wire logic host_d_oe,
  input wire logic dev_d_oe,
  // Device side
  input wire logic power_down_n,
  input wire logic osc_pll_stop,
  input wire logic mem_page0_select_n,
  input wire logic mem_page1_select_n,
  input wire logic mem_output_enable_n,
  input wire logic ee_cs_n,
  input wire logic ee_sck,
  input wire logic [7:0] core_stop,
  input wire logic [7:0] dsp_core_idle,
  input wire logic control_cpu_rom,
  input wire logic boot_run,
  input wire bsl_pkg::bsl_src_t boot_src
);
  timeunit 1ns;
  timeprecision 1ps;
  import bsl_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire mem_sel = !mem_page0_select_n || !mem_page1_select_n;

  property p_pre_run_idle;
    !boot_run |-> dsp_core_idle == 8'hff;
  endproperty
  a_pre_run_idle: assert property (p_pre_run_idle)
    else $error("core running before boot done");
  property p_cpu_rom;
    control_cpu_rom != boot_run;
  endproperty
  a_cpu_rom: assert property (p_cpu_rom)
    else $error("cpu rom flag wrong");
  property p_core_stop;
    boot_run && $past(boot_run) && $stable(core_stop)
      |-> dsp_core_idle == core_stop;
  endproperty
  a_core_stop: assert property (p_core_stop)
    else $error("core idle does not follow stop mask");
  property p_run_hold;
    boot_run |=> boot_run && $stable(boot_src);
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("boot source changed after start");
  property p_pd_stop;
    osc_pll_stop == !power_down_n;
  endproperty
  a_pd_stop: assert property (p_pd_stop)
    else $error("clock stop does not follow power down");
  property p_page_excl;
    mem_page0_select_n || mem_page1_select_n;
  endproperty
  a_page_excl: assert property (p_page_excl)
    else $error("both memory pages selected");
  property p_sel_oe;
    $rose(mem_sel)
      |-> mem_output_enable_n[*2] ##1 !mem_output_enable_n[*3];
  endproperty
  a_sel_oe: assert property (p_sel_oe)
    else $error("output enable timing after select wrong");
  property p_spi_idle;
    ee_cs_n |-> !ee_sck;
  endproperty
  a_spi_idle: assert property (p_spi_idle)
    else $error("serial clock high while deselected");
  property p_spi_sck;
    $rose(ee_sck) |-> ee_sck[*4] ##1 !ee_sck;
  endproperty
  a_spi_sck: assert property (p_spi_sck)
    else $error("serial clock high phase wrong");
  property p_irq_clr;
    $rose(rd_n) && !cs_n && !host_register_select && irq |-> ##[1:2] !irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("irq not cleared by data read");
  property p_no_clash;
    !(host_d_oe && dev_d_oe);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive data bus");
endmodule

// *** bsl_dev.sv ***
`include "bsl_cfg.svh"
module bsl_dev (
  // System
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_down_n,
  output logic osc_pll_stop,
  // Boot straps
  input wire logic debug_serial_in,
  input wire logic card_boot_select,
  // Host port
  bsl_if.dev hp,
  // External memory
  output logic [21:0] mem_addr,
  input wire logic [15:0] mem_data,
  output logic mem_page0_select_n,
  output logic mem_page1_select_n,
  output logic mem_output_enable_n,
  // Card byte stream
  input wire logic card_present,
  input wire logic [7:0] card_byte,
  input wire logic card_valid,
  output logic card_ready,
  output logic [7:0] card_sector,
  // Serial EEPROM
  output logic ee_cs_n,
  output logic ee_sck,
  output logic ee_mosi,
  input wire logic ee_miso,
  // Firmware controls
  input wire logic [7:0] core_stop,
  input wire logic slow_clk_sel,
  output logic slow_tick,
  // Loaded image and boot status
  output logic fw_we,
  output logic [15:0] fw_addr,
  output logic [15:0] fw_data,
  output logic boot_run,
  output bsl_pkg::bsl_src_t boot_src,
  output logic [22:0] start_addr,
  output logic debugger_start,
  output logic control_cpu_rom,
  output logic [7:0] dsp_core_idle,
  output logic boot_fail
);
  import bsl_pkg::*;

  bsl_dev_s_t s_r;
  bsl_dev_s_t s_nxt;
  logic load_done;

  assign load_done = s_r.hdr_cnt == 2'h2 && s_r.wcnt == s_r.len;

  always_comb
  begin
    logic rd_act;
    logic wr_act;
    logic spi_byte;
    logic bvld;
    logic [7:0] bval;
    logic [2:0] cnt_p1;
    rd_act = !hp.cs_n && !hp.rd_n;
    wr_act = !hp.cs_n && !hp.wr_n;
    spi_byte = 1'b0;
    bvld = 1'b0;
    bval = 8'h00;
    cnt_p1 = s_r.mem_cnt + 3'h1;
    s_nxt = s_r;
    s_nxt.fw_we = 1'b0;
    s_nxt.rd_q = rd_act;
    s_nxt.wr_q = wr_act;
    if (wr_act)
    begin
      s_nxt.wlat = hp.d;
    end
    // Data read finished
    if (s_r.rd_q && !rd_act && !hp.host_register_select)
    begin
      s_nxt.tx_pend = 1'b0;
    end
    // SPI engine: sample on rising, shift on falling
    if (s_r.spi_sel)
    begin
      if (s_r.div_cnt == 4'(`BSL_SPI_HALF - 1))
      begin
        s_nxt.div_cnt = 4'h0;
        if (!s_r.sck)
        begin
          s_nxt.sck = 1'b1;
          s_nxt.rx_sh = {s_r.rx_sh[6:0], ee_miso};
        end
        else
        begin
          s_nxt.sck = 1'b0;
          s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
          s_nxt.mosi_sh = {s_r.mosi_sh[6:0], 1'b0};
          spi_byte = s_r.bit_cnt == 3'h7;
        end
      end
      else
      begin
        s_nxt.div_cnt = s_r.div_cnt + 4'h1;
      end
    end
    // Slow clock tick
    s_nxt.slow_cnt = s_r.slow_cnt + 8'h01;
    s_nxt.slow_tick = !slow_clk_sel || s_r.slow_cnt == `BSL_SLOW_LAST;
    // Byte source for the loader
    case (s_r.src)
      SRC_CARD:
      begin
        bvld = card_valid;
        bval = card_byte;
      end
      SRC_EE:
      begin
        bvld = spi_byte;
        bval = s_r.rx_sh;
      end
      SRC_HOST:
      begin
        bvld = s_r.rx_full;
        bval = s_r.rx_byte;
      end
      default:
      begin
        bvld = 1'b0;
        bval = 8'h00;
      end
    endcase
    if (s_r.st != DS_LOAD || load_done)
    begin
      bvld = 1'b0;
    end
    case (s_r.st)
      DS_SENSE:
      begin
        if (debug_serial_in)
        begin
          s_nxt.st = DS_DEBUG;
        end
        else
        begin
          s_nxt.st = DS_ROM;
          s_nxt.mem_cs = 1'b1;
          s_nxt.mem_cnt = 3'h0;
          s_nxt.mem_addr = 23'h0;
        end
      end
      DS_DEBUG:
      begin
        s_nxt.st = DS_DEBUG;
      end
      DS_ROM:
      begin
        s_nxt.mem_cnt = cnt_p1;
        s_nxt.mem_oe = cnt_p1 >= 3'(`BSL_MEM_OE_DLY) &&
          cnt_p1 < 3'(`BSL_MEM_OE_DLY + `BSL_MEM_OE_LEN);
        if (s_r.mem_cnt == 3'(`BSL_MEM_OE_DLY + `BSL_MEM_OE_LEN - 1))
        begin
          s_nxt.mem_cnt = 3'h0;
          s_nxt.mem_oe = 1'b0;
          if (s_r.mem_addr == 23'h0)
          begin
            s_nxt.rom_w0 = mem_data;
            s_nxt.mem_addr = 23'h1;
          end
          else
          begin
            s_nxt.mem_cs = 1'b0;
            if (s_r.rom_w0[7:0] == `BSL_SIG0 && mem_data[7:0] == `BSL_SIG1)
            begin
              s_nxt.st = DS_RUN;
              s_nxt.src = SRC_ROM;
              s_nxt.start_addr = `BSL_ROM_JUMP;
            end
            else
            begin
              s_nxt.st = DS_CARD_CHK;
            end
          end
        end
      end
      DS_CARD_CHK:
      begin
        if (!card_boot_select)
        begin
          s_nxt.st = DS_CARD_WAIT;
        end
        else
        begin
          s_nxt.st = DS_EE;
          s_nxt.spi_sel = 1'b1;
          s_nxt.mosi_sh = `BSL_EE_READ;
          s_nxt.div_cnt = 4'h0;
          s_nxt.bit_cnt = 3'h0;
          s_nxt.ee_idx = 3'h0;
        end
      end
      DS_CARD_WAIT:
      begin
        if (card_present)
        begin
          s_nxt.st = DS_LOAD;
          s_nxt.src = SRC_CARD;
        end
      end
      DS_EE:
      begin
        if (spi_byte)
        begin
          s_nxt.ee_idx = s_r.ee_idx + 3'h1;
          if ((s_r.ee_idx == `BSL_EE_SIG0_IDX && s_r.rx_sh != `BSL_SIG0) ||
            (s_r.ee_idx == `BSL_EE_SIG1_IDX && s_r.rx_sh != `BSL_SIG1))
          begin
            s_nxt.spi_sel = 1'b0;
            s_nxt.sck = 1'b0;
            s_nxt.st = DS_ACK1;
          end
          else if (s_r.ee_idx == `BSL_EE_SIG1_IDX)
          begin
            s_nxt.st = DS_LOAD;
            s_nxt.src = SRC_EE;
          end
        end
      end
      DS_ACK1:
      begin
        s_nxt.out_byte = `BSL_HOST_ACK;
        s_nxt.tx_pend = 1'b1;
        s_nxt.st = DS_LOAD;
        s_nxt.src = SRC_HOST;
      end
      DS_LOAD:
      begin
        if (load_done)
        begin
          s_nxt.spi_sel = 1'b0;
          s_nxt.sck = 1'b0;
          s_nxt.st = (s_r.src == SRC_HOST) ? DS_ACK2 : DS_RUN;
        end
        else if (bvld)
        begin
          if (s_r.src == SRC_HOST)
          begin
            s_nxt.rx_full = 1'b0;
          end
          if (s_r.hdr_cnt == 2'h0)
          begin
            s_nxt.len[7:0] = bval;
            s_nxt.hdr_cnt = 2'h1;
          end
          else if (s_r.hdr_cnt == 2'h1)
          begin
            s_nxt.len[15:8] = bval;
            s_nxt.hdr_cnt = 2'h2;
          end
          else if (!s_r.half)
          begin
            s_nxt.lo_byte = bval;
            s_nxt.half = 1'b1;
          end
          else
          begin
            s_nxt.half = 1'b0;
            s_nxt.fw_we = 1'b1;
            s_nxt.fw_data = {bval, s_r.lo_byte};
            s_nxt.fw_addr = s_r.wcnt;
            s_nxt.wcnt = s_r.wcnt + 16'h1;
            if (s_r.src == SRC_HOST && s_r.wcnt == 16'h0 &&
              {bval, s_r.lo_byte} != {`BSL_SIG1, `BSL_SIG0})
            begin
              s_nxt.st = DS_FAIL;
            end
          end
        end
      end
      DS_ACK2:
      begin
        s_nxt.out_byte = `BSL_HOST_ACK;
        s_nxt.tx_pend = 1'b1;
        s_nxt.st = DS_RUN;
      end
      DS_RUN:
      begin
        s_nxt.st = DS_RUN;
      end
      DS_FAIL:
      begin
        s_nxt.st = DS_FAIL;
      end
      default:
      begin
        s_nxt.st = DS_SENSE;
      end
    endcase
    // Host byte written; set wins over the loader's clear
    if (s_r.wr_q && !wr_act && !hp.host_register_select)
    begin
      s_nxt.rx_full = 1'b1;
      s_nxt.rx_byte = s_r.wlat;
    end
    s_nxt.d_o = hp.host_register_select ?
      {!s_r.tx_pend, s_r.rx_full, 6'h00} : s_r.out_byte;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign hp.irq = s_r.tx_pend;
  assign hp.dev_d_o = s_r.d_o;
  assign hp.dev_d_oe = !hp.cs_n && !hp.rd_n;
  assign mem_addr = s_r.mem_addr[21:0];
  assign mem_page0_select_n = !(s_r.mem_cs && !s_r.mem_addr[`BSL_PAGE_BIT]);
  assign mem_page1_select_n = !(s_r.mem_cs && s_r.mem_addr[`BSL_PAGE_BIT]);
  assign mem_output_enable_n = !s_r.mem_oe;
  assign card_ready = s_r.st == DS_LOAD && s_r.src == SRC_CARD && !load_done;
  assign card_sector = `BSL_CARD_SECTOR;
  assign ee_cs_n = !s_r.spi_sel;
  assign ee_sck = s_r.sck;
  assign ee_mosi = s_r.mosi_sh[7];
  assign osc_pll_stop = !power_down_n;
  assign slow_tick = s_r.slow_tick;
  assign fw_we = s_r.fw_we;
  assign fw_addr = s_r.fw_addr;
  assign fw_data = s_r.fw_data;
  assign boot_run = s_r.st == DS_RUN;
  assign boot_src = s_r.src;
  assign start_addr = s_r.start_addr;
  assign debugger_start = s_r.st == DS_DEBUG;
  assign control_cpu_rom = s_r.st != DS_RUN;
  assign dsp_core_idle = (s_r.st == DS_RUN) ? core_stop : 8'hff;
  assign boot_fail = s_r.st == DS_FAIL;
endmodule

// *** bsl_host.sv ***
`include "bsl_cfg.svh"
module bsl_host (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata,
  // Image byte stream
  input wire logic [7:0] img_byte,
  input wire logic img_valid,
  output logic img_ready,
  // Parallel port
  bsl_if.host hp
);
  import bsl_pkg::*;

  bsl_host_s_t s_r;
  bsl_host_s_t s_nxt;

  assign img_ready = s_r.st == HS_FETCH && s_r.bcnt >= 18'h2;

  always_comb
  begin
    logic op_end;
    logic go_poll;
    logic go_rd;
    logic go_wr;
    logic [17:0] total;
    op_end = s_r.op_cnt == 4'(`BSL_HOST_STB_CYC + 1);
    go_poll = 1'b0;
    go_rd = 1'b0;
    go_wr = 1'b0;
    total = 18'({s_r.len, 1'b0}) + 18'h2;
    s_nxt = s_r;
    s_nxt.rdata = 16'h0;
    if (reg_re)
    begin
      case (reg_addr)
        `BSL_REG_LEN: s_nxt.rdata = s_r.len;
        `BSL_REG_STAT: s_nxt.rdata = {13'h0, s_r.err, s_r.done,
          s_r.st != HS_IDLE && s_r.st != HS_DONE};
        default: s_nxt.rdata = 16'h0;
      endcase
    end
    if (reg_we && reg_addr == `BSL_REG_LEN)
    begin
      s_nxt.len = reg_wdata;
    end
    // Bus cycle timing
    if (s_r.st == HS_POLL || s_r.st == HS_WRITE || s_r.st == HS_RDDATA)
    begin
      s_nxt.op_cnt = s_r.op_cnt + 4'h1;
      if (s_r.op_cnt == 4'(`BSL_HOST_STB_CYC - 1))
      begin
        s_nxt.rd = 1'b0;
        s_nxt.wr = 1'b0;
        s_nxt.rdat = hp.d;
      end
      if (s_r.op_cnt == 4'(`BSL_HOST_STB_CYC))
      begin
        s_nxt.cs = 1'b0;
      end
    end
    case (s_r.st)
      HS_IDLE, HS_DONE:
      begin
        if (reg_we && reg_addr == `BSL_REG_CTRL && reg_wdata[0])
        begin
          s_nxt.hph = 2'h0;
          s_nxt.done = 1'b0;
          s_nxt.err = 1'b0;
          go_poll = 1'b1;
        end
      end
      HS_POLL:
      begin
        if (op_end)
        begin
          if (s_r.hph == 2'h1)
          begin
            if (!s_r.rdat[`BSL_ST_RF])
            begin
              s_nxt.st = HS_FETCH;
            end
            else
            begin
              go_poll = 1'b1;
            end
          end
          else if (!s_r.rdat[`BSL_ST_TE])
          begin
            go_rd = 1'b1;
          end
          else
          begin
            go_poll = 1'b1;
          end
        end
      end
      HS_FETCH:
      begin
        if (s_r.bcnt < 18'h2)
        begin
          s_nxt.dq = s_r.bcnt[0] ? s_r.len[15:8] : s_r.len[7:0];
          go_wr = 1'b1;
        end
        else if (img_valid)
        begin
          s_nxt.dq = img_byte;
          go_wr = 1'b1;
        end
      end
      HS_WRITE:
      begin
        if (op_end)
        begin
          s_nxt.bcnt = s_r.bcnt + 18'h1;
          if (s_r.bcnt + 18'h1 == total)
          begin
            s_nxt.hph = 2'h2;
          end
          go_poll = 1'b1;
        end
      end
      HS_RDDATA:
      begin
        if (op_end)
        begin
          if (s_r.rdat == `BSL_HOST_ACK && s_r.hph == 2'h0)
          begin
            s_nxt.hph = 2'h1;
            s_nxt.bcnt = 18'h0;
            go_poll = 1'b1;
          end
          else
          begin
            s_nxt.st = HS_DONE;
            s_nxt.done = 1'b1;
            s_nxt.err = s_r.rdat != `BSL_HOST_ACK;
          end
        end
      end
      default:
      begin
        s_nxt.st = HS_IDLE;
      end
    endcase
    if (go_poll || go_rd || go_wr)
    begin
      s_nxt.st = go_poll ? HS_POLL : (go_rd ? HS_RDDATA : HS_WRITE);
      s_nxt.sel = go_poll;
      s_nxt.rd = !go_wr;
      s_nxt.wr = go_wr;
      s_nxt.cs = 1'b1;
      s_nxt.op_cnt = 4'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign hp.cs_n = !s_r.cs;
  assign hp.host_register_select = s_r.sel;
  assign hp.rd_n = !s_r.rd;
  assign hp.wr_n = !s_r.wr;
  assign hp.host_d_o = s_r.dq;
  assign hp.host_d_oe = s_r.cs && s_r.st == HS_WRITE;
endmodule

// *** bsl_if.sv ***
interface bsl_if;
  logic cs_n;
  logic host_register_select;
  logic rd_n;
  logic wr_n;
  logic irq;
  logic [7:0] host_d_o;
  logic host_d_oe;
  logic [7:0] dev_d_o;
  logic dev_d_oe;
  logic [7:0] d;

  // Resolved data bus, pulled high when nobody drives
  assign d = host_d_oe ? host_d_o : (dev_d_oe ? dev_d_o : 8'hff);

  modport dev (
    input cs_n, host_register_select, rd_n, wr_n, d,
    output dev_d_o, dev_d_oe, irq
  );
  modport host (
    output cs_n, host_register_select, rd_n, wr_n, host_d_o, host_d_oe,
    input d, irq
  );
endinterface

// *** bsl_pkg.sv ***
package bsl_pkg;
  typedef enum logic [3:0] {
    DS_SENSE = 4'h0,
    DS_DEBUG = 4'h1,
    DS_ROM = 4'h2,
    DS_CARD_CHK = 4'h3,
    DS_CARD_WAIT = 4'h4,
    DS_EE = 4'h5,
    DS_ACK1 = 4'h6,
    DS_LOAD = 4'h7,
    DS_ACK2 = 4'h8,
    DS_RUN = 4'h9,
    DS_FAIL = 4'ha
  } bsl_dev_st_t;

  typedef enum logic [1:0] {
    SRC_CARD = 2'h0,
    SRC_EE = 2'h1,
    SRC_HOST = 2'h2,
    SRC_ROM = 2'h3
  } bsl_src_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_POLL = 3'h1,
    HS_FETCH = 3'h2,
    HS_WRITE = 3'h3,
    HS_RDDATA = 3'h4,
    HS_DONE = 3'h5
  } bsl_host_st_t;

  typedef struct packed {
    bsl_dev_st_t st;
    bsl_src_t src;
    logic rd_q;
    logic wr_q;
    logic tx_pend;
    logic rx_full;
    logic [7:0] wlat;
    logic [7:0] rx_byte;
    logic [7:0] out_byte;
    logic [7:0] d_o;
    logic mem_cs;
    logic mem_oe;
    logic [2:0] mem_cnt;
    logic [22:0] mem_addr;
    logic [22:0] start_addr;
    logic [15:0] rom_w0;
    logic spi_sel;
    logic sck;
    logic [7:0] mosi_sh;
    logic [7:0] rx_sh;
    logic [2:0] bit_cnt;
    logic [2:0] ee_idx;
    logic [3:0] div_cnt;
    logic [1:0] hdr_cnt;
    logic half;
    logic [7:0] lo_byte;
    logic [15:0] len;
    logic [15:0] wcnt;
    logic fw_we;
    logic [15:0] fw_addr;
    logic [15:0] fw_data;
    logic [7:0] slow_cnt;
    logic slow_tick;
  } bsl_dev_s_t;

  typedef struct packed {
    bsl_host_st_t st;
    logic [1:0] hph;
    logic [3:0] op_cnt;
    logic cs;
    logic rd;
    logic wr;
    logic sel;
    logic [7:0] dq;
    logic [7:0] rdat;
    logic [17:0] bcnt;
    logic [15:0] len;
    logic done;
    logic err;
    logic [15:0] rdata;
  } bsl_host_s_t;
endpackage
